// ===== hdl/ssr_status_readout.sv
// Sticky status register read out serially on the fault pin.
module ssr_status_readout #(
    parameter int IDLE_CYC = ssr_pkg::IDLE_CLEAR_CYC
) (
    input wire logic sys_clk, // System clock.
    input wire logic rstn, // Asynchronous reset, active low.
    input wire logic mode_clk_pin, // Mode input used as shift clock.
    input wire logic io_range_high, // IO supply within 4.75 V to 5.25 V.
    input wire logic io_range_low, // IO supply within 2.2 V to 4.75 V.
    input wire logic local_wake_flag, // Live local wake source flag.
    input wire logic remote_wake_flag, // Live remote wake source flag.
    input wire logic node_cfg_flag, // High for node configuration.
    input wire logic supply_up_flag, // Power-on flag.
    input wire logic bus_err_flag, // Bus error flag.
    input wire logic temp_high_flag, // High temperature flag.
    input wire logic temp_med_flag, // Medium temperature flag.
    input wire logic transmit_gate_stuck_flag, // Gate clamped flag.
    input wire logic low_battery_flag, // Battery undervoltage flag.
    input wire logic low_core_supply_flag, // Core undervoltage flag.
    input wire logic low_io_supply_flag, // IO undervoltage flag.
    input wire logic star_locked, // High while in star locked mode.
    input wire logic branch_clash, // Collision detected on branches.
    output logic fault_status_pin, // Serial status out, low means set.
    output logic error_flag // Summary of latched bits S4-S12.
);
    localparam int CW = $clog2(IDLE_CYC + 1);
    if (IDLE_CYC < 1) begin
        $error("IDLE_CYC must be at least one");
    end

    logic [2:0] sync;
    logic [2:0] next_sync;
    logic clk_lvl;
    logic next_clk_lvl;
    logic [ssr_pkg::STATUS_W-1:0] sticky;
    logic [ssr_pkg::STATUS_W-1:0] next_sticky;
    logic [ssr_pkg::IDX_W-1:0] idx;
    logic [ssr_pkg::IDX_W-1:0] next_idx;
    logic read_done;
    logic next_read_done;
    logic [CW-1:0] idle;
    logic [CW-1:0] next_idle;
    logic next_fault;
    logic next_error;
    logic [ssr_pkg::STATUS_W-1:0] src;
    logic [ssr_pkg::STATUS_W-1:0] view;
    logic fall;
    logic edge_seen;
    logic access_ok;
    logic idle_hit;

    always_comb begin
        // The wake and configuration bits are mirrors, the rest latch.
        // detected clash latched
        src = {branch_clash, star_locked, low_io_supply_flag,
               low_core_supply_flag, low_battery_flag,
               transmit_gate_stuck_flag, temp_med_flag, temp_high_flag,
               bus_err_flag, supply_up_flag, 3'h0};
        view = sticky;
        view[ssr_pkg::BIT_LOCAL_WAKE] = local_wake_flag;
        view[ssr_pkg::BIT_REMOTE_WAKE] = remote_wake_flag;
        view[ssr_pkg::BIT_NODE_CFG] = node_cfg_flag;
        access_ok = (!low_io_supply_flag && io_range_high) ||
                    (!low_core_supply_flag && io_range_low);
        next_sync = {sync[1:0], mode_clk_pin};
        next_clk_lvl = clk_lvl;
        if (sync[2] == sync[1]) begin
            next_clk_lvl = sync[1];
        end
        fall = clk_lvl && !next_clk_lvl;
        edge_seen = clk_lvl != next_clk_lvl;
        // An edge in the expiry cycle restarts the wait instead.
        idle_hit = read_done && !edge_seen && (idle == CW'(IDLE_CYC));
        next_idle = idle;
        if (edge_seen) begin
            next_idle = '0;
        end else if (idle != CW'(IDLE_CYC)) begin
            next_idle = idle + CW'(1);
        end
        next_idx = idx;
        next_read_done = read_done;
        if (fall && access_ok) begin
            next_read_done = 1'b1;
            if (idx == ssr_pkg::IDX_W'(ssr_pkg::STATUS_W - 1)) begin
                next_idx = '0;
            end else begin
                next_idx = idx + ssr_pkg::IDX_W'(1);
            end
        end
        next_sticky = sticky;
        if (idle_hit) begin
            next_sticky = sticky & ~(ssr_pkg::CLEARABLE_MASK & ~src);
            next_read_done = 1'b0;
            next_idx = '0;
        end
        next_sticky = next_sticky | src;
        next_sticky[2:0] = 3'h0;
        next_fault = 1'b1;
        if (access_ok) begin
            next_fault = !view[next_idx];
        end
        next_error = |(next_sticky & ssr_pkg::CLEARABLE_MASK);
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            sync <= 3'h7;
            clk_lvl <= 1'b1;
            sticky <= ssr_pkg::STATUS_RESET;
            idx <= '0;
            read_done <= 1'b0;
            idle <= '0;
            fault_status_pin <= 1'b1;
            error_flag <= 1'b0;
        end else begin
            sync <= next_sync;
            clk_lvl <= next_clk_lvl;
            sticky <= next_sticky;
            idx <= next_idx;
            read_done <= next_read_done;
            idle <= next_idle;
            fault_status_pin <= next_fault;
            error_flag <= next_error;
        end
    end

    error_track_a: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        error_flag == |(sticky & ssr_pkg::CLEARABLE_MASK))
        else $error("summary error mismatch");
    bus_err_latch_a: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        bus_err_flag |=> sticky[ssr_pkg::BIT_BUS_ERR])
        else $error("bus error not latched");
    supply_hold_a: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        sticky[ssr_pkg::BIT_SUPPLY_UP] |=> sticky[ssr_pkg::BIT_SUPPLY_UP])
        else $error("supply up bit lost");
    clear_idle_a: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        (sticky[ssr_pkg::BIT_CLASH] && !idle_hit)
        |=> sticky[ssr_pkg::BIT_CLASH])
        else $error("latched bit cleared early");
    clear_done_a: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        (idle_hit && !temp_high_flag) |=> !sticky[ssr_pkg::BIT_TEMP_HIGH])
        else $error("released bit not cleared");
    no_access_a: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        !$past(access_ok) |-> fault_status_pin)
        else $error("pin driven low without access");
    idx_step_a: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        (fall && access_ok && !idle_hit && idx == 4'h0) |=> idx == 4'h1)
        else $error("index did not advance");
    wake_show_a: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        (access_ok && next_idx == 4'h0)
        |=> fault_status_pin == !$past(local_wake_flag))
        else $error("local wake not shown");
    error_rise_a: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        (|(src & ssr_pkg::CLEARABLE_MASK)) |=> error_flag)
        else $error("summary error not raised");
    supply_latch_a: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        supply_up_flag |=> sticky[ssr_pkg::BIT_SUPPLY_UP])
        else $error("supply up not latched");
    temp_med_latch_a: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        temp_med_flag |=> sticky[ssr_pkg::BIT_TEMP_MED])
        else $error("medium temperature not latched");
    clash_latch_a: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        branch_clash |=> sticky[ssr_pkg::BIT_CLASH])
        else $error("clash not latched");
    no_read_hold_a: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        (!read_done && sticky[ssr_pkg::BIT_BUS_ERR])
        |=> sticky[ssr_pkg::BIT_BUS_ERR])
        else $error("bit cleared without a read");
    refused_idx_a: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        (fall && !access_ok && !idle_hit) |=> idx == $past(idx))
        else $error("index moved without access");

    sequence shift_fall_s;
        fall && access_ok;
    endsequence
    idx_last_a: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        shift_fall_s ##0 (idx == 4'hb) |=> idx == 4'hc)
        else $error("index missed the last bit");
endmodule

// ===== hdl/ssr_pkg.sv
// Constants for the serial sticky status readout block.
package ssr_pkg;
    localparam int STATUS_W = 13;
    localparam int BIT_LOCAL_WAKE = 0;
    localparam int BIT_REMOTE_WAKE = 1;
    localparam int BIT_NODE_CFG = 2;
    localparam int BIT_SUPPLY_UP = 3;
    localparam int BIT_BUS_ERR = 4;
    localparam int BIT_TEMP_HIGH = 5;
    localparam int BIT_TEMP_MED = 6;
    localparam int BIT_GATE_STUCK = 7;
    localparam int BIT_LOW_BAT = 8;
    localparam int BIT_LOW_CORE = 9;
    localparam int BIT_LOW_IO = 10;
    localparam int BIT_STAR_LOCK = 11;
    localparam int BIT_CLASH = 12;
    localparam int IDX_W = 4;
    localparam logic [STATUS_W-1:0] STATUS_RESET = 13'h0000;
    localparam logic [STATUS_W-1:0] CLEARABLE_MASK = 13'h1ff0;
    localparam int CLK_MHZ = 100;
    // Idle time on the shift clock before clearing, in microseconds.
    localparam int IDLE_CLEAR_US = 40;
    localparam int IDLE_CLEAR_CYC = IDLE_CLEAR_US * CLK_MHZ;
endpackage

// ===== verif/ssr_host_model.sv
// Host model that reads the status bits over the mode input.
module ssr_host_model (
    input wire logic fault_status_pin, // Serial status from the device.
    output logic mode_clk_pin // Shift clock, idle high.
);
    timeunit 1ns;
    timeprecision 100ps;
    initial mode_clk_pin = 1'b1;
    task automatic read_status(output logic [12:0] v);
        // Step off the system clock grid so no edge meets a sample.
        #1;
        for (int i = 0; i < 13; i++) begin
            v[i] = ~fault_status_pin;
            if (i < 12) begin
                mode_clk_pin = 1'b0;
                #62.5;
                mode_clk_pin = 1'b1;
                #62.5;
            end
        end
    endtask
endmodule

// ===== verif/ssr_status_readout_tb.sv
// Self-checking bench for the serial status readout.
module ssr_status_readout_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int IDLE = 20;
    logic sys_clk, rstn, io_range_high, io_range_low;
    logic mode_clk_pin, fault_status_pin, error_flag;
    logic [12:0] src, sticky, hold, got, e;
    int fail_count, comparisons;
    ssr_status_readout #(.IDLE_CYC(IDLE)) uut (
        .sys_clk(sys_clk), .rstn(rstn), .mode_clk_pin(mode_clk_pin),
        .io_range_high(io_range_high), .io_range_low(io_range_low),
        .local_wake_flag(src[0]), .remote_wake_flag(src[1]),
        .node_cfg_flag(src[2]), .supply_up_flag(src[3]),
        .bus_err_flag(src[4]), .temp_high_flag(src[5]),
        .temp_med_flag(src[6]), .transmit_gate_stuck_flag(src[7]),
        .low_battery_flag(src[8]), .low_core_supply_flag(src[9]),
        .low_io_supply_flag(src[10]), .star_locked(src[11]),
        .branch_clash(src[12]), .fault_status_pin(fault_status_pin),
        .error_flag(error_flag));
    ssr_host_model host (.fault_status_pin(fault_status_pin),
        .mode_clk_pin(mode_clk_pin));
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic check(input logic [12:0] seen, input logic [12:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("fail_count %0d comparisons %0d", fail_count, comparisons);
        if (fail_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    function automatic logic [12:0] expect_bits(input logic [12:0] s,
        input logic [12:0] live);
        return {s[12:3], live[2:0]};
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    initial begin
        repeat (100000) @(posedge sys_clk);
        fail_count++;
        complete_run();
    end
    initial begin
        fail_count = 0;
        comparisons = 0;
        rstn = 1'b0;
        src = '0;
        sticky = '0;
        io_range_high = 1'b1;
        io_range_low = 1'b0;
        void'($urandom(54));
        cyc(6);
        rstn = 1'b1;
        for (int r = 0; r < 6; r++) begin
            // Odd rounds use the low supply range with the core flag clear.
            io_range_high = ~r[0];
            io_range_low = r[0];
            hold = 13'($urandom) & 13'h19f0;
            src = (r == 0) ? 13'h1fff : 13'($urandom);
            sticky = sticky | {src[12:3], 3'h0};
            cyc(2);
            src = hold | 13'($urandom % 8);
            sticky = sticky | hold;
            cyc(8);
            host.read_status(got);
            e = expect_bits(sticky, src);
            check(got & 13'h0007, e & 13'h0007);
            check(got & 13'h00f8, e & 13'h00f8);
            check(got, e);
            check(got & 13'h1f60, e & 13'h1f60);
            check(got & 13'h1f00, e & 13'h1f00);
            check({12'h0, error_flag}, {12'h0, |sticky[12:4]});
            cyc(IDLE + 8);
            sticky = sticky & ~(13'h1ff0 & ~hold);
            check({12'h0, error_flag}, {12'h0, |sticky[12:4]});
        end
        io_range_high = 1'b0;
        io_range_low = 1'b0;
        src = 13'h0007;
        cyc(4);
        host.read_status(got);
        check(got, 13'h0000);
        // Mid-run reset must drop every latched bit, S3 included.
        cyc(2);
        rstn = 1'b0;
        cyc(2);
        check({11'h0, error_flag, fault_status_pin}, 13'h0001);
        rstn = 1'b1;
        io_range_high = 1'b1;
        src = 13'h0005;
        cyc(4);
        host.read_status(got);
        check(got, 13'h0005);
        complete_run();
    end
endmodule
